/* src/bb_regs_pkg.sv */
package bb_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// register numbers (7-bit index, byte address = index*2)
	localparam logic [6:0] IDX_PART_VERSION = 7'h00;
	localparam logic [6:0] IDX_IO_POLARITY = 7'h01;
	localparam logic [6:0] IDX_RX_INIT = 7'h02;
	localparam logic [6:0] IDX_SHORT_PRE = 7'h03;
	localparam logic [6:0] IDX_LONG_PRE = 7'h04;
	localparam logic [6:0] IDX_TX_SIGNAL = 7'h05;
	localparam logic [6:0] IDX_TX_SERVICE = 7'h06;
	localparam logic [6:0] IDX_LOCKED_TRACK = 7'h21;
	localparam logic [6:0] IDX_GAIN_SETUP = 7'h2F;
	localparam logic [6:0] IDX_SIG_QUALITY = 7'h33;
	localparam logic [6:0] IDX_DETECT_STATUS = 7'h3D;
	localparam logic [6:0] IDX_RX_STRENGTH = 7'h3E;
	// polarity and other register bit positions
	localparam int POL_RX_ROT = 7;
	localparam int POL_TX_ROT = 6;
	localparam int POL_TRANSMIT_CLOCK_OUT = 5;
	localparam int POL_TXRDY = 4;
	localparam int POL_TXEN = 3;
	localparam int POL_CCA = 2;
	localparam int POL_RXRDY = 1;
	localparam int POL_RXCLK = 0;
	localparam int INIT_BIT = 0;
	localparam int PRE_SEL_BIT = 3;
	localparam int LOCKED_SVC_BIT = 2;
	localparam int LOCKED_EN_BIT = 6;
	localparam int ED_STATUS_BIT = 4;
	// reset values and ramp length
	localparam logic [7:0] POLARITY_RST = 8'h00;
	localparam logic [7:0] SHORT_PRE_RST = 8'h38;
	localparam logic [7:0] LONG_PRE_RST = 8'h80;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] INIT_RST = 8'h01;
	localparam logic [7:0] PA_RAMP_SYMBOLS = 8'h02;
	// identity codes, values arbitrary
	localparam logic [3:0] PART_CODE = 4'hA;
	localparam logic [3:0] VERSION_CODE = 4'h5;
	// symbol timing: 1 us symbol at 25 MHz
	localparam int SYMBOL_NS = 1000;
	localparam int CLK_NS = 40;
	localparam int SYMBOL_CYCLES = SYMBOL_NS / CLK_NS;
	// early-late loop saturates at plus or minus this many steps
	localparam int TRACK_STEP_LIMIT = 72;
	typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_BODY} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_ACQUIRE, RX_TRACK} rx_state_e;
endpackage

/* src/bb_config_status_regs.sv */
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module bb_config_status_regs
	import bb_regs_pkg::*;
#(
	parameter int CORR_TAPS = 22
)
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [bb_regs_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [bb_regs_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [bb_regs_pkg::DATA_W-1:0] reg_rdata_out,
	// mac pins
	input wire logic transmit_enable_in,
	input wire logic receive_enable_in,
	output logic transmit_ready_out,
	output logic receive_data_ready_out,
	output logic clear_channel_indication_out,
	output logic transmit_clock_out,
	output logic receive_clock_out,
	// receive front end
	input wire logic signed [7:0] rx_i_in,
	input wire logic signed [7:0] rx_q_in,
	input wire logic [7:0] received_strength_in,
	input wire logic [7:0] energy_threshold_in,
	input wire logic signal_present_in,
	input wire logic rx_header_done_in,
	input wire logic rx_data_valid_in,
	input wire logic locked_peer_in,
	// transmit modulator
	input wire logic tx_q_in,
	output logic tx_q_out,
	output logic tx_preamble_out,
	// tracking results
	output logic signed [7:0] rx_q_corr_out,
	output logic carrier_loop_active_out,
	output logic carrier_derived_timing_out,
	output logic signed [7:0] symbol_phase_out,
	output logic signed [11:0] correlator_out,
	output logic gain_reset_out
);
	import bb_regs_pkg::*;

	function automatic logic [7:0] abs8(input logic signed [7:0] v);
		abs8 = v[7] ? 8'(-v) : 8'(v);
	endfunction

	// registers
	logic [7:0] polarity_q;
	logic [7:0] init_q;
	logic [7:0] short_pre_q;
	logic [7:0] long_pre_q;
	logic [7:0] tx_signal_q;
	logic [7:0] tx_service_q;
	logic [7:0] locked_en_q;
	logic [7:0] gain_setup_q;
	logic [7:0] signal_quality_q;
	logic [7:0] strength_q;
	logic energy_detect_q;
	// read data falls back to zero so a stale value is never taken for an answer
	logic [7:0] rdata_q;

	// pin synchronisers: three stages, change accepted when 2 and 3 agree
	// the first stage may go metastable, so only the later two are compared
	logic [2:0] txen_sync_q;
	logic [2:0] rxen_sync_q;
	logic txen_stable_q;
	logic rxen_stable_q;

	// receive state, declared early because the measurement logic reads it
	rx_state_e rx_state_q;

	// decode
	wire [6:0] reg_index = reg_addr_in[7:1];
	wire soft_init = init_q[INIT_BIT];
	// enable pin seen through its programmed active level
	wire tx_active = txen_stable_q ^ polarity_q[POL_TXEN];
	wire wr_pol = reg_write_in && reg_index == IDX_IO_POLARITY;
	// the receive init write is dropped silently while either path is busy
	wire rx_idle = !tx_active && !rxen_stable_q;
	wire wr_init = reg_write_in && reg_index == IDX_RX_INIT && rx_idle;
	wire wr_short = reg_write_in && reg_index == IDX_SHORT_PRE && !tx_active;
	wire wr_long = reg_write_in && reg_index == IDX_LONG_PRE && !tx_active;
	wire wr_sig = reg_write_in && reg_index == IDX_TX_SIGNAL;
	wire wr_svc = reg_write_in && reg_index == IDX_TX_SERVICE;
	wire wr_lock = reg_write_in && reg_index == IDX_LOCKED_TRACK;
	wire wr_gain = reg_write_in && reg_index == IDX_GAIN_SETUP;

	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (reg_index)
			IDX_PART_VERSION: rd_mux = {PART_CODE, VERSION_CODE};
			IDX_IO_POLARITY: rd_mux = polarity_q;
			IDX_RX_INIT: rd_mux = init_q;
			IDX_SHORT_PRE: rd_mux = short_pre_q;
			IDX_LONG_PRE: rd_mux = long_pre_q;
			IDX_TX_SIGNAL: rd_mux = tx_signal_q;
			IDX_TX_SERVICE: rd_mux = tx_service_q;
			IDX_LOCKED_TRACK: rd_mux = locked_en_q;
			IDX_GAIN_SETUP: rd_mux = gain_setup_q;
			IDX_SIG_QUALITY: rd_mux = signal_quality_q;
			IDX_DETECT_STATUS: rd_mux = 8'(energy_detect_q) << ED_STATUS_BIT;
			IDX_RX_STRENGTH: rd_mux = strength_q;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			polarity_q <= POLARITY_RST;
			init_q <= INIT_RST;
			short_pre_q <= SHORT_PRE_RST;
			long_pre_q <= LONG_PRE_RST;
			tx_signal_q <= ZERO_RST;
			tx_service_q <= ZERO_RST;
			locked_en_q <= ZERO_RST;
			gain_setup_q <= ZERO_RST;
			rdata_q <= ZERO_RST;
		end
		else
		begin
			if (wr_pol) polarity_q <= reg_wdata_in;
			if (wr_init) init_q <= reg_wdata_in;
			if (wr_short) short_pre_q <= reg_wdata_in;
			if (wr_long) long_pre_q <= reg_wdata_in;
			if (wr_sig) tx_signal_q <= reg_wdata_in;
			if (wr_svc) tx_service_q <= reg_wdata_in;
			if (wr_lock) locked_en_q <= reg_wdata_in;
			if (wr_gain) gain_setup_q <= reg_wdata_in;
			rdata_q <= reg_read_in ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata_out = rdata_q;

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			txen_sync_q <= 3'h0;
			rxen_sync_q <= 3'h0;
			txen_stable_q <= 1'b0;
			rxen_stable_q <= 1'b0;
		end
		else
		begin
			txen_sync_q <= {txen_sync_q[1:0], transmit_enable_in};
			rxen_sync_q <= {rxen_sync_q[1:0], receive_enable_in};
			if (txen_sync_q[2] == txen_sync_q[1]) txen_stable_q <= txen_sync_q[2];
			if (rxen_sync_q[2] == rxen_sync_q[1]) rxen_stable_q <= rxen_sync_q[2];
		end
	end

	// receive measurements; learned state cleared while soft init is set
	wire energy_hit = received_strength_in >= energy_threshold_in;
	// learned state: kept internal, the controller only sees its effects
	logic [7:0] noise_floor_q;
	logic [7:0] dc_offset_q;
	logic [7:0] packet_count_q;
	logic [7:0] carrier_err_q;
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in || soft_init)
		begin
			noise_floor_q <= 8'h00;
			dc_offset_q <= 8'h00;
			packet_count_q <= 8'h00;
			strength_q <= 8'h00;
			signal_quality_q <= 8'h00;
			energy_detect_q <= 1'b0;
			carrier_err_q <= 8'h00;
		end
		else
		begin
			strength_q <= received_strength_in;
			energy_detect_q <= energy_hit;
			if (!signal_present_in) noise_floor_q <= received_strength_in;
			dc_offset_q <= 8'(rx_i_in);
			if (rx_header_done_in) packet_count_q <= packet_count_q + 8'h01;
			carrier_err_q <= abs8(rx_q_corr_out);
			// snr: signal minus residual carrier loop error
			if (rx_state_q == RX_TRACK)
				signal_quality_q <= (abs8(rx_i_in) > carrier_err_q) ?
					8'(abs8(rx_i_in) - carrier_err_q) : 8'h00;
		end
	end
	assign gain_reset_out = soft_init;

	// receive state: acquisition then tracking
	// leaves tracking as soon as the enable pin or the signal goes away
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in || soft_init)
			rx_state_q <= RX_IDLE;
		else
		begin
			unique case (rx_state_q)
				RX_IDLE: if (rxen_stable_q && signal_present_in) rx_state_q <= RX_ACQUIRE;
				RX_ACQUIRE: if (rx_header_done_in) rx_state_q <= RX_TRACK;
				RX_TRACK: if (!rxen_stable_q || !signal_present_in) rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// parallel correlator, two samples per chip, every other stage tapped
	// no reset: the taps flush within one correlator length of real samples
	logic signed [7:0] corr_sr_q [0:2*CORR_TAPS-1];
	logic signed [11:0] corr_sum;
	always_comb
	begin
		corr_sum = 12'sh000;
		for (int k = 0; k < CORR_TAPS; k++)
			corr_sum = corr_sum + 12'(corr_sr_q[2*k]);
	end
	always_ff @(posedge ref_clk_in)
	begin
		corr_sr_q[0] <= rx_i_in;
		for (int k = 1; k < 2*CORR_TAPS; k++)
			corr_sr_q[k] <= corr_sr_q[k-1];
		correlator_out <= corr_sum;
	end

	// symbol timing
	wire locked_mode = tx_service_q[LOCKED_SVC_BIT] && locked_en_q[LOCKED_EN_BIT]
		&& locked_peer_in;
	logic signed [7:0] phase_q;
	// signed limits: an unsigned compare would stall the loop below zero
	wire signed [7:0] phase_max = signed'(8'(TRACK_STEP_LIMIT));
	wire signed [7:0] phase_min = -phase_max;
	// the interpolator saturates, so long offsets cannot be followed forever
	logic carrier_active_q;
	logic derived_q;
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in || soft_init)
		begin
			phase_q <= 8'sh00;
			carrier_active_q <= 1'b0;
			derived_q <= 1'b0;
		end
		else
		begin
			carrier_active_q <= rx_state_q == RX_TRACK;
			derived_q <= locked_mode;
			if (rx_state_q == RX_TRACK && rx_data_valid_in)
			begin
				if (locked_mode)
					phase_q <= 8'(rx_q_corr_out >>> 4);
				else if (rx_i_in > 8'sh00 && phase_q < phase_max)
					phase_q <= phase_q + 8'sh01;
				else if (rx_i_in < 8'sh00 && phase_q > phase_min)
					phase_q <= phase_q - 8'sh01;
			end
		end
	end
	assign carrier_loop_active_out = carrier_active_q;
	assign carrier_derived_timing_out = derived_q;
	assign symbol_phase_out = phase_q;

	// q polarity on both paths
	logic signed [7:0] rxq_q;
	logic txq_q;
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			rxq_q <= 8'sh00;
			txq_q <= 1'b0;
		end
		else
		begin
			rxq_q <= polarity_q[POL_RX_ROT] ? 8'(-rx_q_in) : rx_q_in;
			txq_q <= tx_q_in ^ polarity_q[POL_TX_ROT];
		end
	end
	assign rx_q_corr_out = rxq_q;
	assign tx_q_out = txq_q;

	// transmit preamble: programmed count plus ramp symbols
	// dropping the enable mid-preamble abandons the frame without a body
	tx_state_e tx_state_q;
	logic [8:0] sym_left_q;
	logic [4:0] sym_tick_q;
	wire [7:0] pre_count = tx_signal_q[PRE_SEL_BIT] ? short_pre_q : long_pre_q;
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_state_q <= TX_IDLE;
			sym_left_q <= 9'h000;
			sym_tick_q <= 5'h00;
		end
		else
		begin
			sym_tick_q <= (sym_tick_q == 5'(SYMBOL_CYCLES - 1)) ? 5'h00 : sym_tick_q + 5'h01;
			unique case (tx_state_q)
				TX_IDLE:
					if (tx_active)
					begin
						tx_state_q <= TX_PREAMBLE;
						sym_left_q <= 9'(pre_count) + 9'(PA_RAMP_SYMBOLS);
						sym_tick_q <= 5'h00;
					end
				TX_PREAMBLE:
					if (!tx_active) tx_state_q <= TX_IDLE;
					else if (sym_tick_q == 5'(SYMBOL_CYCLES - 1))
					begin
						if (sym_left_q == 9'h001) tx_state_q <= TX_BODY;
						sym_left_q <= sym_left_q - 9'h001;
					end
				TX_BODY: if (!tx_active) tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// pin levels with polarity
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_preamble_out <= 1'b0;
			transmit_ready_out <= 1'b0;
			receive_data_ready_out <= 1'b0;
			clear_channel_indication_out <= 1'b0;
			transmit_clock_out <= 1'b0;
			receive_clock_out <= 1'b0;
		end
		else
		begin
			tx_preamble_out <= tx_state_q == TX_PREAMBLE;
			transmit_ready_out <= (tx_state_q == TX_BODY) ^ polarity_q[POL_TXRDY];
			receive_data_ready_out <= (rx_state_q == RX_TRACK && rx_data_valid_in)
				^ polarity_q[POL_RXRDY];
			// channel is clear when no energy: active level set by bit 2
			clear_channel_indication_out <= !energy_detect_q ^ !polarity_q[POL_CCA];
			transmit_clock_out <= (sym_tick_q < 5'(SYMBOL_CYCLES / 2)) ^ polarity_q[POL_TRANSMIT_CLOCK_OUT];
			receive_clock_out <= (sym_tick_q < 5'(SYMBOL_CYCLES / 2)) ^ polarity_q[POL_RXCLK];
		end
	end
endmodule // bb_config_status_regs

/* verif/bb_regs_assertions.sv */
`timescale 1ns/100ps
module bb_regs_checker
	import bb_regs_pkg::*;
#(
	parameter int CORR_TAPS = 22
)
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [DATA_W-1:0] reg_rdata_out,
	// datapath and status
	input wire logic tx_q_in,
	input wire logic tx_q_out,
	input wire logic signed [7:0] rx_q_in,
	input wire logic signed [7:0] rx_q_corr_out,
	input wire logic tx_preamble_out,
	input wire logic transmit_ready_out,
	input wire logic gain_reset_out
);
	logic [7:0] pol_q;
	wire logic [6:0] idx;
	assign idx = reg_addr_in[7:1];
	// polarity writes are never refused, so a shadow copy is exact
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			pol_q <= POLARITY_RST;
		else if (reg_write_in && idx == IDX_IO_POLARITY)
			pol_q <= reg_wdata_in;
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_rdata_idle;
		!$past(reg_read_in) |-> reg_rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_id_read;
		reg_read_in && idx == IDX_PART_VERSION |=> reg_rdata_out == {PART_CODE, VERSION_CODE};
	endproperty
	a_id_read: assert property (p_id_read) else $error("ident value wrong");
	property p_unmapped;
		reg_read_in && idx == 7'h7F |=> reg_rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_init_read;
		reg_read_in && idx == IDX_RX_INIT |=> reg_rdata_out[INIT_BIT] == $past(gain_reset_out);
	endproperty
	a_init_read: assert property (p_init_read) else $error("gain hold differs from init");
	property p_tx_q;
		tx_q_out == ($past(tx_q_in) ^ $past(pol_q[POL_TX_ROT]));
	endproperty
	a_tx_q: assert property (p_tx_q) else $error("transmit Q sense wrong");
	property p_rx_q;
		rx_q_corr_out == ($past(pol_q[POL_RX_ROT]) ? -$past(rx_q_in) : $past(rx_q_in));
	endproperty
	a_rx_q: assert property (p_rx_q) else $error("receive Q sense wrong");
	property p_ready_after_pre;
		$fell(tx_preamble_out) |-> ##[0:2] transmit_ready_out == !pol_q[POL_TXRDY];
	endproperty
	a_ready_after_pre: assert property (p_ready_after_pre) else $error("ready missing");
	property p_pre_min;
		$rose(tx_preamble_out) |-> tx_preamble_out [*8];
	endproperty
	a_pre_min: assert property (p_pre_min) else $error("preamble too short");
	c_pre: cover property ($fell(tx_preamble_out));
	c_init: cover property ($fell(gain_reset_out));
	c_id: cover property (reg_read_in && idx == IDX_PART_VERSION);
endmodule // bb_regs_checker

/* verif/mac_pins_model.sv */
`timescale 1ns/100ps
module mac_pins_model
(
	// clock
	input wire logic ref_clk_in,
	// commands from the bench
	input wire logic tx_go_in,
	input wire logic rx_go_in,
	input wire logic tx_active_low_in,
	// pins towards the baseband
	output logic transmit_enable_out,
	output logic receive_enable_out
);
	// the controller drives its enable at the level it has programmed
	always_ff @(posedge ref_clk_in)
	begin
		transmit_enable_out <= tx_go_in ^ tx_active_low_in;
		receive_enable_out <= rx_go_in;
	end
endmodule // mac_pins_model

/* verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import bb_regs_pkg::*;
	logic ref_clk_in, sys_rst_in, reg_write_in, reg_read_in, tx_go, rx_go, tx_low;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, received_strength_in;
	logic [7:0] energy_threshold_in, v;
	logic signed [7:0] rx_i_in, rx_q_in;
	logic transmit_enable_in, receive_enable_in, transmit_ready_out, receive_data_ready_out;
	logic clear_channel_indication_out, signal_present_in, rx_header_done_in, rx_data_valid_in;
	logic locked_peer_in, tx_q_in, tx_q_out, tx_preamble_out, gain_reset_out;
	logic transmit_clock_out, receive_clock_out, carrier_loop_active_out;
	logic carrier_derived_timing_out;
	logic signed [7:0] symbol_phase_out;
	logic signed [11:0] correlator_out;
	int err_count, n_compared, cyc;
	bb_config_status_regs #(.CORR_TAPS(22)) u_bb_config_status_regs (.ref_clk_in, .sys_rst_in,
		.reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
		.transmit_enable_in, .receive_enable_in, .transmit_ready_out, .receive_data_ready_out,
		.clear_channel_indication_out, .transmit_clock_out, .receive_clock_out, .rx_i_in,
		.rx_q_in, .received_strength_in, .energy_threshold_in, .signal_present_in,
		.rx_header_done_in, .rx_data_valid_in, .locked_peer_in, .tx_q_in, .tx_q_out,
		.tx_preamble_out, .rx_q_corr_out(), .carrier_loop_active_out,
		.carrier_derived_timing_out, .symbol_phase_out, .correlator_out, .gain_reset_out);
	mac_pins_model u_mac_pins_model (.ref_clk_in, .tx_go_in(tx_go), .rx_go_in(rx_go),
		.tx_active_low_in(tx_low), .transmit_enable_out(transmit_enable_in),
		.receive_enable_out(receive_enable_in));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	task automatic report_and_stop;
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// datapath inputs stay quiet until well after reset so the first edges are clean
	always @(posedge ref_clk_in)
	begin
		cyc <= cyc + 1;
		tx_q_in <= (cyc > 12) ? ~tx_q_in : 1'b0;
		rx_q_in <= (cyc > 12) ? {2'b00, cyc[5:0]} : 8'sh00;
		if (cyc == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_read_in <= 1'b0;
		#1;
		v = reg_rdata_out;
		chk(name, exp, v & m);
	endtask
	task automatic t_reset_map;
		rdchk("ident", 8'h00, 8'hFF, {PART_CODE, VERSION_CODE});
		wr(8'h00, 8'h33);
		rdchk("ident_ro", 8'h01, 8'hFF, {PART_CODE, VERSION_CODE});
		rdchk("polarity", 8'h02, 8'hFF, POLARITY_RST);
		rdchk("short_pre", 8'h07, 8'hFF, SHORT_PRE_RST);
		rdchk("long_pre", 8'h08, 8'hFF, LONG_PRE_RST);
		rdchk("unmapped", 8'hFE, 8'hFF, 8'h00);
		wr(8'h02, 8'hE5);
		rdchk("polarity_rw", 8'h02, 8'hFF, 8'hE5);
		wr(8'h02, 8'h00);
	endtask
	task automatic t_init;
		chk("gain_hold", 1'b1, gain_reset_out);
		rx_go <= 1'b1;
		wr(8'h5E, 8'h42);
		rdchk("gain_setup", 8'h5E, 8'hFF, 8'h42);
		wr(8'h04, 8'h00);
		rdchk("init_refused", 8'h04, 8'hFF, INIT_RST);
		rx_go <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		wr(8'h04, 8'h00);
		rdchk("init_clear", 8'h04, 8'hFF, 8'h00);
		chk("gain_run", 1'b0, gain_reset_out);
	endtask
	task automatic t_levels;
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h02, i ? 8'h16 : 8'h00);
			repeat (6) @(posedge ref_clk_in);
			#1;
			chk("clear_level", i, clear_channel_indication_out);
			chk("rx_ready_idle", i, receive_data_ready_out);
			chk("tx_ready_idle", i, transmit_ready_out);
		end
		received_strength_in <= 8'hC0;
		repeat (6) @(posedge ref_clk_in);
		#1;
		chk("clear_busy", 1'b0, clear_channel_indication_out);
		rdchk("energy_on", 8'h7A, 8'h10, 8'h10);
		rdchk("strength", 8'h7C, 8'hFF, 8'hC0);
		energy_threshold_in <= 8'hD0;
		repeat (6) @(posedge ref_clk_in);
		rdchk("energy_off", 8'h7A, 8'h10, 8'h00);
		wr(8'h02, 8'h00);
	endtask
	task automatic t_preamble(input logic [7:0] pol, input logic [7:0] sel,
		input logic [7:0] a, input logic [7:0] cnt);
		int n;
		// pin and polarity flip on the same edge, so the enable never looks active
		tx_low <= pol[POL_TXEN];
		repeat (3) @(posedge ref_clk_in);
		wr(8'h02, pol);
		wr(8'h0A, sel);
		wr(a, cnt);
		tx_go <= 1'b1;
		n = 0;
		while (tx_preamble_out !== 1'b1 && n < 20)
		begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		n = 0;
		while (tx_preamble_out === 1'b1 && n < 2000)
		begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		chk("preamble_len", (cnt + 2) * SYMBOL_CYCLES, n);
		chk("tx_ready_on", !pol[POL_TXRDY], transmit_ready_out);
		wr(a, 8'h10);
		tx_go <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		rdchk("pre_locked", a, 8'hFF, cnt);
	endtask
	task automatic t_track;
		logic a;
		#1;
		a = transmit_clock_out;
		wr(8'h02, 8'h20);
		repeat (23) @(posedge ref_clk_in);
		#1;
		chk("tx_clk_inv", !a, transmit_clock_out);
		chk("rx_clk_same", a, receive_clock_out);
		wr(8'h02, 8'h01);
		repeat (2) @(posedge ref_clk_in);
		#1;
		chk("rx_clk_inv", 1'b1, transmit_clock_out ^ receive_clock_out);
		wr(8'h02, 8'h00);
		rx_go <= 1'b1;
		signal_present_in <= 1'b1;
		repeat (8) @(posedge ref_clk_in);
		#1;
		chk("carrier_acquire", 1'b0, carrier_loop_active_out);
		rx_header_done_in <= 1'b1;
		@(posedge ref_clk_in);
		rx_header_done_in <= 1'b0;
		rx_data_valid_in <= 1'b1;
		rx_i_in <= 8'sh20;
		repeat (4) @(posedge ref_clk_in);
		#1;
		chk("carrier_track", 1'b1, carrier_loop_active_out);
		chk("rx_ready_on", 1'b1, receive_data_ready_out);
		chk("early_late", 1'b1, symbol_phase_out > 8'sh00);
		chk("derived_off", 1'b0, carrier_derived_timing_out);
		locked_peer_in <= 1'b1;
		wr(8'h0C, 8'h04);
		wr(8'h42, 8'h40);
		repeat (44) @(posedge ref_clk_in);
		#1;
		chk("derived_on", 1'b1, carrier_derived_timing_out);
		chk("correlator", 12'h2C0, correlator_out);
		rx_go <= 1'b0;
		signal_present_in <= 1'b0;
		rx_data_valid_in <= 1'b0;
		rx_i_in <= 8'sh00;
		locked_peer_in <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
	endtask
	initial
	begin
		sys_rst_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		reg_write_in = 1'b0;
		reg_read_in = 1'b0;
		rx_i_in = 8'sh00;
		received_strength_in = 8'h10;
		energy_threshold_in = 8'h40;
		signal_present_in = 1'b0;
		rx_header_done_in = 1'b0;
		rx_data_valid_in = 1'b0;
		locked_peer_in = 1'b0;
		tx_go = 1'b0;
		rx_go = 1'b0;
		tx_low = 1'b0;
		repeat (8) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		t_reset_map();
		t_init();
		t_levels();
		t_track();
		t_preamble(8'h00, 8'h00, 8'h08, 8'h03);
		t_preamble(8'h18, 8'h08, 8'h06, 8'h04);
		report_and_stop();
	end
endmodule // testbench
bind bb_config_status_regs bb_regs_checker #(.CORR_TAPS(CORR_TAPS)) u_bb_regs_checker (
	.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
	.reg_rdata_out, .tx_q_in, .tx_q_out, .rx_q_in, .rx_q_corr_out, .tx_preamble_out,
	.transmit_ready_out, .gain_reset_out);
